// file: hdl/pps_top.sv
// Pulse pattern sequencer with AXI4-Lite registers and pattern store.
// Assumes trig_i synchronous-ish to clk_i; clock source is only reported.
`timescale 1ns/10ps
module pps_top #(
	parameter int DEPTH = 1024 // Pattern entries, a power of two
) (
	input wire logic clk_i,                // 25 MHz clock
	input wire logic rst_i,                // Sync reset, high
	input wire logic [7:0] s_axi_awaddr_i, // Write address
	input wire logic s_axi_awvalid_i,      // Write address valid
	output logic s_axi_awready_o,          // Write address ready
	input wire logic [31:0] s_axi_wdata_i, // Write data
	input wire logic [3:0] s_axi_wstrb_i,  // Byte enables
	input wire logic s_axi_wvalid_i,       // Write data valid
	output logic s_axi_wready_o,           // Write data ready
	output logic [1:0] s_axi_bresp_o,      // Write response
	output logic s_axi_bvalid_o,           // Write response valid
	input wire logic s_axi_bready_i,       // Write response ready
	input wire logic [7:0] s_axi_araddr_i, // Read address
	input wire logic s_axi_arvalid_i,      // Read address valid
	output logic s_axi_arready_o,          // Read address ready
	output logic [31:0] s_axi_rdata_o,     // Read data
	output logic [1:0] s_axi_rresp_o,     // Read response
	output logic s_axi_rvalid_o,           // Read data valid
	input wire logic s_axi_rready_i,       // Read data ready
	input wire logic trig_i,               // External trigger
	output logic [7:0] dig_o,              // Digital channels
	output logic [11:0] dac0_o,            // analog_code_first DAC
	output logic [11:0] dac1_o,            // analog_code_second DAC
	output logic [1:0] clk_sel_o,          // Clock source code
	output logic present_o,                // pattern_present_flag
	output logic playing_o,                // playing_flag
	output logic completed_o               // completed_flag
);

	localparam int AW = $clog2(DEPTH);
	localparam int EW = 72;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		pps_pkg::pps_state_t st;
		logic [2:0] src;
		logic mode;
		logic [1:0] csel;
		logic [7:0] od;
		logic [15:0] oa0;
		logic [15:0] oa1;
		logic [7:0] cd;
		logic [15:0] ca0;
		logic [15:0] ca1;
		logic [31:0] sdur;
		logic [7:0] sd;
		logic [15:0] sa0;
		logic [15:0] sa1;
		logic [7:0] fd;
		logic [15:0] fa0;
		logic [15:0] fa1;
		logic fok;
		logic [63:0] rep;
		logic [63:0] left;
		logic [AW:0] cnt;
		logic [AW-1:0] idx;
		logic signed [33:0] acc;
		logic [pps_pkg::PAD_W-1:0] sum;
		logic present;
		logic once;
		logic t1;
		logic t2;
		logic t3;
		logic aw_ok;
		logic w_ok;
		logic [7:0] awa;
		logic [31:0] wd;
		logic [3:0] ws;
		logic bv;
		logic [1:0] br;
		logic rv;
		logic [31:0] rd;
		logic [1:0] rr;
	} pps_regs_t;

	pps_regs_t q, d;
	logic [EW-1:0] mem [DEPTH];
	logic wr, push, go, adv, hw_go, rise, fall, last;
	logic [8:0] cmd;
	logic [7:0] wa, ra;
	logic [31:0] v;
	logic [AW-1:0] nidx, lastidx;
	logic [EW-1:0] ent, pdata;
	logic signed [33:0] an, ndur;
	logic [pps_pkg::PAD_W-1:0] pad;

	// Reset image of all state
	function automatic pps_regs_t init();
		pps_regs_t r;
		r = '0;
		r.st = pps_pkg::ST_IDLE;
		r.rep = pps_pkg::REP_RST;
		return r;
	endfunction

	// Merge new write data into an old value by byte enable
	function automatic logic [31:0] mrg(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Pattern store
	// ----------------------------------------------------------------
	// Entry layout: duration, mask, first code, second code
	assign pdata = {q.sdur, q.sd, v[15:0], v[31:16]};

	// Append staged entry on write of the analog pair
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[q.cnt[AW-1:0]] <= pdata;
		end
	end

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		wa = {q.awa[7:2], 2'h0};
		ra = {s_axi_araddr_i[7:2], 2'h0};
		wr = q.aw_ok && q.w_ok && !q.bv;
		cmd = '0;
		push = 1'b0;
		go = 1'b0;
		v = '0;
		// Bus channel acceptance
		if (s_axi_awvalid_i && s_axi_awready_o) begin
			d.aw_ok = 1'b1;
			d.awa = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && s_axi_wready_o) begin
			d.w_ok = 1'b1;
			d.wd = s_axi_wdata_i;
			d.ws = s_axi_wstrb_i;
		end
		if (q.bv && s_axi_bready_i) begin
			d.bv = 1'b0;
		end
		if (q.rv && s_axi_rready_i) begin
			d.rv = 1'b0;
		end
		// Register writes
		if (wr) begin
			d.aw_ok = 1'b0;
			d.w_ok = 1'b0;
			d.bv = 1'b1;
			d.br = pps_pkg::RESP_OKAY;
			case (wa)
				pps_pkg::OFF_CTRL: begin
					v = mrg('0, q.wd, q.ws);
					cmd = v[8:0];
				end
				pps_pkg::OFF_CFG: begin
					v = mrg({26'h0, q.csel, q.mode, q.src}, q.wd, q.ws);
					d.src = v[2:0];
					d.mode = v[3];
					d.csel = v[5:4];
				end
				pps_pkg::OFF_DUR: d.sdur = mrg(q.sdur, q.wd, q.ws);
				pps_pkg::OFF_DIG: begin
					v = mrg({24'h0, q.sd}, q.wd, q.ws);
					d.sd = v[7:0];
				end
				pps_pkg::OFF_ANA: begin
					v = mrg({q.sa1, q.sa0}, q.wd, q.ws);
					d.sa0 = v[15:0];
					d.sa1 = v[31:16];
					push = !q.cnt[AW];
				end
				pps_pkg::OFF_REPLO: d.rep[31:0] = mrg(q.rep[31:0], q.wd, q.ws);
				pps_pkg::OFF_REPHI: d.rep[63:32] = mrg(q.rep[63:32], q.wd, q.ws);
				pps_pkg::OFF_STAT, pps_pkg::OFF_CNT: d.br = pps_pkg::RESP_OKAY;
				default: d.br = pps_pkg::RESP_SLVERR;
			endcase
		end
		// Padding of the pattern to whole granules
		if (push) begin
			d.cnt = q.cnt + 1'b1;
			d.sum = q.sum + q.sdur[pps_pkg::PAD_W-1:0];
		end
		// Register reads
		if (s_axi_arvalid_i && s_axi_arready_o) begin
			d.rv = 1'b1;
			d.rr = pps_pkg::RESP_OKAY;
			case (ra)
				pps_pkg::OFF_CTRL: d.rd = '0;
				pps_pkg::OFF_CFG: d.rd = {26'h0, q.csel, q.mode, q.src};
				pps_pkg::OFF_STAT: d.rd = {28'h0, q.once, completed_o,
					playing_o, present_o};
				pps_pkg::OFF_DUR: d.rd = q.sdur;
				pps_pkg::OFF_DIG: d.rd = {24'h0, q.sd};
				pps_pkg::OFF_ANA: d.rd = {q.sa1, q.sa0};
				pps_pkg::OFF_REPLO: d.rd = q.rep[31:0];
				pps_pkg::OFF_REPHI: d.rd = q.rep[63:32];
				pps_pkg::OFF_CNT: d.rd = 32'(q.cnt);
				default: begin
					d.rd = '0;
					d.rr = pps_pkg::RESP_SLVERR;
				end
			endcase
		end
		// Trigger synchroniser and edge detect
		d.t1 = trig_i;
		d.t2 = q.t1;
		d.t3 = q.t2;
		rise = q.t2 && !q.t3;
		fall = !q.t2 && q.t3;
		case (q.src)
			pps_pkg::SRC_SW: hw_go = cmd[pps_pkg::C_START];
			pps_pkg::SRC_RISE: hw_go = rise;
			pps_pkg::SRC_FALL: hw_go = fall;
			pps_pkg::SRC_BOTH: hw_go = rise || fall;
			default: hw_go = 1'b0;
		endcase
		// Entry fetch and run-length timing
		lastidx = AW'(q.cnt - 1'b1);
		last = q.idx == lastidx;
		nidx = (q.st == pps_pkg::ST_PLAY && !last) ? q.idx + 1'b1 : '0;
		ent = mem[nidx];
		pad = '0 - q.sum;
		ndur = $signed({2'h0, ent[71:40]});
		if (nidx == lastidx) begin
			ndur = ndur + $signed({31'h0, pad});
		end
		an = q.acc - 34'(pps_pkg::CLK_NS);
		adv = q.st == pps_pkg::ST_PLAY && an <= 0;
		// Commands and sequencing
		if (cmd[pps_pkg::C_RST]) begin
			d.st = pps_pkg::ST_IDLE;
			d.src = pps_pkg::SRC_IMM;
			d.mode = pps_pkg::MODE_NORMAL;
			d.csel = pps_pkg::CLK_INT;
			{d.od, d.oa0, d.oa1} = '0;
			{d.cd, d.ca0, d.ca1} = '0;
			{d.fd, d.fa0, d.fa1, d.fok} = '0;
			d.rep = pps_pkg::REP_RST;
			d.cnt = '0;
			d.sum = '0;
			d.present = 1'b0;
			d.once = 1'b0;
		end else if (cmd[pps_pkg::C_CONST] || cmd[pps_pkg::C_CZERO]) begin
			d.st = pps_pkg::ST_IDLE;
			d.once = 1'b0;
			d.cd = cmd[pps_pkg::C_CONST] ? q.sd : '0;
			d.ca0 = cmd[pps_pkg::C_CONST] ? q.sa0 : '0;
			d.ca1 = cmd[pps_pkg::C_CONST] ? q.sa1 : '0;
			{d.od, d.oa0, d.oa1} = {d.cd, d.ca0, d.ca1};
		end else if (cmd[pps_pkg::C_NEW]) begin
			d.st = pps_pkg::ST_IDLE;
			d.cnt = '0;
			d.sum = '0;
			d.fok = 1'b0;
			d.present = 1'b0;
			{d.od, d.oa0, d.oa1} = {q.cd, q.ca0, q.ca1};
		end else if (cmd[pps_pkg::C_FORCE] && (q.st == pps_pkg::ST_PLAY ||
			q.st == pps_pkg::ST_ARMED)) begin
			d.st = pps_pkg::ST_IDLE;
			if (q.fok) begin
				{d.od, d.oa0, d.oa1} = {q.fd, q.fa0, q.fa1};
			end else begin
				{d.od, d.oa0, d.oa1} = {q.cd, q.ca0, q.ca1};
			end
		end else if (cmd[pps_pkg::C_STREAM]) begin
			d.present = 1'b1;
			d.st = pps_pkg::ST_ARMED;
			{d.od, d.oa0, d.oa1} = {q.cd, q.ca0, q.ca1};
			go = q.src == pps_pkg::SRC_IMM;
		end else begin
			case (q.st)
				pps_pkg::ST_IDLE: d.st = pps_pkg::ST_IDLE;
				pps_pkg::ST_ARMED: go = hw_go;
				pps_pkg::ST_PLAY: begin
					d.acc = an;
					if (adv) begin
						d.idx = nidx;
						d.acc = an + ndur;
						{d.od, d.oa0, d.oa1} = ent[39:0];
						if (last && !q.rep[63]) begin
							if (q.left > 64'h1) begin
								d.left = q.left - 64'h1;
							end else begin
								d.st = pps_pkg::ST_FINAL;
								{d.od, d.oa0, d.oa1} = {q.fd, q.fa0, q.fa1};
							end
						end
					end
				end
				pps_pkg::ST_FINAL: begin
					// Retrigger of a finished pattern
					go = hw_go && (q.mode == pps_pkg::MODE_NORMAL || q.once);
					if (go) begin
						d.once = 1'b0;
					end
				end
				default: d.st = pps_pkg::ST_IDLE;
			endcase
		end
		// Start of a pattern run
		if (go) begin
			if (q.cnt == '0 || q.rep == '0) begin
				d.st = pps_pkg::ST_FINAL;
				{d.od, d.oa0, d.oa1} = {q.fd, q.fa0, q.fa1};
			end else begin
				d.st = pps_pkg::ST_PLAY;
				d.idx = '0;
				d.left = q.rep;
				d.acc = ndur;
				{d.od, d.oa0, d.oa1} = ent[39:0];
			end
		end
		// One further start allowed in one-shot mode
		if (cmd[pps_pkg::C_REARM] && q.st == pps_pkg::ST_FINAL && !go) begin
			d.once = 1'b1;
		end
		if (cmd[pps_pkg::C_FINAL] && !cmd[pps_pkg::C_RST]) begin
			{d.fd, d.fa0, d.fa1, d.fok} = {q.sd, q.sa0, q.sa1, 1'b1};
		end
	end

	// Register the whole state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= init();
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign s_axi_awready_o = !q.aw_ok;
	assign s_axi_wready_o = !q.w_ok;
	assign s_axi_bvalid_o = q.bv;
	assign s_axi_bresp_o = q.br;
	assign s_axi_arready_o = !q.rv;
	assign s_axi_rvalid_o = q.rv;
	assign s_axi_rdata_o = q.rd;
	assign s_axi_rresp_o = q.rr;
	assign dig_o = q.od;            // Bit n to channel n
	assign dac0_o = q.oa0[15:4];    // Linear full scale
	assign dac1_o = q.oa1[15:4];    // Linear full scale
	assign clk_sel_o = q.csel;
	assign present_o = q.present;
	assign playing_o = q.st == pps_pkg::ST_PLAY;
	assign completed_o = q.st == pps_pkg::ST_FINAL;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_entry_hold: assert property (
		playing_o && !adv && !cmd[pps_pkg::C_FORCE] && cmd == '0
		|=> $stable(dig_o) && $stable(dac0_o))
		else $error("entry changed before its duration");
	a_reset_cmd: assert property (
		cmd[pps_pkg::C_RST] |=> dig_o == '0 && dac0_o == '0 &&
		clk_sel_o == pps_pkg::CLK_INT && !present_o && !playing_o)
		else $error("reset command left state");
	a_load_start: assert property (
		cmd[pps_pkg::C_STREAM] && cmd[6:0] == 7'h00 &&
		q.src == pps_pkg::SRC_IMM && q.cnt != '0 &&
		q.rep != '0 |=> playing_o)
		else $error("start_on_load pattern did not start");
	a_const_halt: assert property (
		cmd[pps_pkg::C_CZERO] && !cmd[pps_pkg::C_RST]
		|=> !playing_o && dig_o == '0 && dac1_o == '0)
		else $error("constant zero not applied");
	a_no_retrig: assert property (
		q.st == pps_pkg::ST_IDLE && !cmd[pps_pkg::C_STREAM]
		|=> !playing_o)
		else $error("retrigger after constant");
	a_armed_const: assert property (
		q.st == pps_pkg::ST_ARMED |-> dig_o == q.cd && dac0_o == q.ca0[15:4])
		else $error("outputs left constant state before start");
	a_final_state: assert property (
		$rose(completed_o) |-> dig_o == q.fd && dac1_o == q.fa1[15:4])
		else $error("end state not applied");
	a_sw_start: assert property (
		q.src == pps_pkg::SRC_SW && cmd == 9'h010 && q.rep != '0 &&
		q.cnt != '0 && (q.st == pps_pkg::ST_ARMED ||
		(q.st == pps_pkg::ST_FINAL && (q.mode == pps_pkg::MODE_NORMAL ||
		q.once))) |=> playing_o)
		else $error("start command ignored");
	a_flag_excl: assert property (
		playing_o && adv && last && !q.rep[63] && q.left == 64'h1 &&
		cmd == '0 |=> !playing_o && completed_o)
		else $error("playing flag kept after last run");
	a_final_held: assert property (
		completed_o && cmd == '0 && !hw_go |=> completed_o)
		else $error("completed flag dropped while end state held");
	a_edge_once: assert property (
		q.src == pps_pkg::SRC_RISE && hw_go |=> !hw_go)
		else $error("one edge gave two starts");

	c_complete: cover property ($rose(completed_o));
	c_retrigger: cover property (completed_o ##1 playing_o);
	c_forced: cover property (playing_o && cmd[pps_pkg::C_FORCE]);

endmodule

// file: hdl/pps_pkg.sv
// Constants and types for the pulse pattern sequencer.
// Assumes a single 25 MHz clock and an AXI4-Lite register port.
package pps_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 25;              // System clock rate
	localparam int CLK_NS = 1000 / CLK_MHZ;   // Nanoseconds per cycle
	localparam int PAD_NS = 8;                // Pattern length granule
	localparam int PAD_W = $clog2(PAD_NS);    // Bits of the granule

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;  // Command strobes
	localparam logic [7:0] OFF_CFG = 8'h04;   // Start, mode, clock
	localparam logic [7:0] OFF_STAT = 8'h08;  // Status flags
	localparam logic [7:0] OFF_DUR = 8'h0c;   // Staged duration
	localparam logic [7:0] OFF_DIG = 8'h10;   // Staged digital mask
	localparam logic [7:0] OFF_ANA = 8'h14;   // Staged analog pair
	localparam logic [7:0] OFF_REPLO = 8'h18; // Repeat count low
	localparam logic [7:0] OFF_REPHI = 8'h1c; // Repeat count high
	localparam logic [7:0] OFF_CNT = 8'h20;   // Entries loaded

	// ----------------------------------------------------------------
	// Command bit positions in the control register
	// ----------------------------------------------------------------
	localparam int C_RST = 0;    // Reset to defaults
	localparam int C_CONST = 1;  // Constant from staging
	localparam int C_CZERO = 2;  // Constant zero
	localparam int C_FORCE = 3;  // Abort to end state
	localparam int C_START = 4;  // Start now
	localparam int C_REARM = 5;  // Rearm once
	localparam int C_NEW = 6;    // Begin new pattern load
	localparam int C_FINAL = 7;  // Staging becomes end state
	localparam int C_STREAM = 8; // Pattern fully loaded

	// ----------------------------------------------------------------
	// Codes and reset values
	// ----------------------------------------------------------------
	localparam logic [2:0] SRC_IMM = 3'h0;   // start_on_load
	localparam logic [2:0] SRC_SW = 3'h1;    // Software start
	localparam logic [2:0] SRC_RISE = 3'h2;  // Rising trigger edge
	localparam logic [2:0] SRC_FALL = 3'h3;  // Falling trigger edge
	localparam logic [2:0] SRC_BOTH = 3'h4;  // Either trigger edge
	localparam logic MODE_NORMAL = 1'h0;     // Auto-rearm
	localparam logic MODE_SINGLE = 1'h1;     // One-shot
	localparam logic [1:0] CLK_INT = 2'h0;   // On-board oscillator
	localparam logic [1:0] CLK_EXT_SAMPLE = 2'h1; // 125 MHz sampling
	localparam logic [1:0] CLK_EXT_REF = 2'h2;    // 10 MHz reference
	localparam logic [63:0] REP_RST = 64'h1; // Repeat count default
	localparam logic [63:0] ENDLESS = 64'hffff_ffff_ffff_ffff; // Marker
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,   // Constant state held
		ST_ARMED = 4'h2,  // Waiting for start event
		ST_PLAY = 4'h4,   // Playing entries
		ST_FINAL = 4'h8   // End state held after completion
	} pps_state_t;

endpackage

// file: verif/pps_host.sv
// Host software model: an AXI4-Lite master with write and read tasks.
// Assumes the sequencer register port on clk_i, one transfer at a time.
`timescale 1ns/10ps
module pps_host (
	input wire logic clk_i,         // Bus clock
	output logic [7:0] awaddr_o,    // Write address
	output logic awvalid_o,         // Write address valid
	input wire logic awready_i,     // Write address ready
	output logic [31:0] wdata_o,    // Write data
	output logic [3:0] wstrb_o,     // Byte enables
	output logic wvalid_o,          // Write data valid
	input wire logic wready_i,      // Write data ready
	input wire logic [1:0] bresp_i, // Write response
	input wire logic bvalid_i,      // Write response valid
	output logic bready_o,          // Write response ready
	output logic [7:0] araddr_o,    // Read address
	output logic arvalid_o,         // Read address valid
	input wire logic arready_i,     // Read address ready
	input wire logic [31:0] rdata_i, // Read data
	input wire logic [1:0] rresp_i, // Read response
	input wire logic rvalid_i,      // Read data valid
	output logic rready_o,          // Read data ready
	output logic hang_o             // An answer never came
);
	// Idle bus at time zero
	initial begin
		{awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
		{araddr_o, arvalid_o, rready_o, hang_o} = '0;
		wstrb_o = 4'hf;
	end

	// Write: address and data offered together, released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		logic ha, hw, hb;
		@(posedge clk_i);
		awaddr_o <= a;
		wdata_o <= d;
		awvalid_o <= 1'b1;
		wvalid_o <= 1'b1;
		bready_o <= 1'b1;
		hb = 1'b0;
		for (n = 0; n < 50 && !hb; n++) begin
			@(negedge clk_i);
			ha = awvalid_o && awready_i;
			hw = wvalid_o && wready_i;
			hb = bvalid_i;
			r = bresp_i;
			@(posedge clk_i);
			if (ha) begin
				awvalid_o <= 1'b0;
				awaddr_o <= ~a;
			end
			if (hw) begin
				wvalid_o <= 1'b0;
				wdata_o <= ~d;
			end
			if (hb)
				bready_o <= 1'b0;
		end
		if (!hb)
			hang_o <= 1'b1;
	endtask

	// Read: address held until taken, data taken with rvalid
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		logic ha, hr;
		@(posedge clk_i);
		araddr_o <= a;
		arvalid_o <= 1'b1;
		rready_o <= 1'b1;
		hr = 1'b0;
		for (n = 0; n < 50 && !hr; n++) begin
			@(negedge clk_i);
			ha = arvalid_o && arready_i;
			hr = rvalid_i;
			d = rdata_i;
			r = rresp_i;
			@(posedge clk_i);
			if (ha) begin
				arvalid_o <= 1'b0;
				araddr_o <= ~a;
			end
			if (hr)
				rready_o <= 1'b0;
		end
		if (!hr)
			hang_o <= 1'b1;
	endtask
endmodule

// file: verif/tb.sv
// Self-checking bench for the pulse pattern sequencer.
// Assumes pps_host drives the register port; trigger driven here.
`timescale 1ns/10ps
module tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic trig_i = 1'b0;
	logic [7:0] awaddr, araddr, dig;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, hang;
	logic [1:0] bresp, rresp, clk_sel, r;
	logic [11:0] dac0, dac1;
	logic present, playing, completed;
	int bad_count = 0;
	int check_count = 0;
	int c1 = 0;
	int c2 = 0;

	// ------------------------------------------------------------
	// Clock, models and design
	// ------------------------------------------------------------
	always #20 clk_i = ~clk_i;

	pps_host host (.clk_i(clk_i), .awaddr_o(awaddr), .awvalid_o(awvalid),
		.awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb),
		.wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp),
		.bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
		.arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
		.rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready),
		.hang_o(hang));

	pps_top #(.DEPTH(16)) dut (.clk_i(clk_i), .rst_i(rst_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .trig_i(trig_i), .dig_o(dig),
		.dac0_o(dac0), .dac1_o(dac1), .clk_sel_o(clk_sel),
		.present_o(present), .playing_o(playing),
		.completed_o(completed));

	// Cycles spent on each entry mask
	always @(negedge clk_i) begin
		c1 += (dig === 8'h01);
		c2 += (dig === 8'h02 && dac1 === 12'h7ff);
	end

	// Lost bus answer ends the run
	always @(posedge hang) begin
		bad_count++;
		end_of_test();
	end

	// ------------------------------------------------------------
	// Helper tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Write, then look at outputs away from the clock edge
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		host.wr(a, v, r);
		@(negedge clk_i);
	endtask

	task automatic cmd(input int b);
		wr(pps_pkg::OFF_CTRL, 32'h1 << b);
	endtask

	// Append one entry: duration, mask, analog pair
	task automatic entry(input logic [31:0] dur, input logic [7:0] m,
		input logic [31:0] a);
		wr(pps_pkg::OFF_DUR, dur);
		wr(pps_pkg::OFF_DIG, {24'h0, m});
		wr(pps_pkg::OFF_ANA, a);
	endtask

	task automatic wait_done;
		int i;
		for (i = 0; i < 200 && completed !== 1'b1; i++)
			@(negedge clk_i);
		if (completed !== 1'b1) begin
			bad_count++;
			end_of_test();
		end
	endtask

	// Look for playing within twelve cycles
	task automatic go(input logic exp);
		int i;
		logic seen;
		seen = 1'b0;
		for (i = 0; i < 12; i++) begin
			@(negedge clk_i);
			if (playing === 1'b1)
				seen = 1'b1;
		end
		chk("start", seen, exp);
		if (seen && exp)
			wait_done();
	endtask

	task automatic trig_to(input logic v, input logic exp);
		@(posedge clk_i);
		trig_i <= v;
		go(exp);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk("dig", dig, 8'h00);
		chk("dac0", dac0, 12'h000);
		chk("clk_sel", clk_sel, 2'h0);
		host.rd(pps_pkg::OFF_CFG, d, r);
		chk("cfg", d, 32'h0);
		host.wr(8'h40, 32'h0, r);
		chk("bresp", r, pps_pkg::RESP_SLVERR);
		host.rd(8'h40, d, r);
		chk("rresp", r, pps_pkg::RESP_SLVERR);
		$display("test reset done");
		// Constant outputs from staging, then zero
		wr(pps_pkg::OFF_DIG, 32'ha5);
		wr(pps_pkg::OFF_ANA, 32'h8001_123f);
		cmd(pps_pkg::C_CONST);
		chk("dig", dig, 8'ha5);
		chk("dac0", dac0, 12'h123);
		chk("dac1", dac1, 12'h800);
		cmd(pps_pkg::C_CZERO);
		chk("dig", dig, 8'h00);
		chk("dac1", dac1, 12'h000);
		$display("test constant done");
		// Load two entries and an end state, play at once
		wr(pps_pkg::OFF_DIG, 32'h3c);
		cmd(pps_pkg::C_CONST);
		cmd(pps_pkg::C_NEW);
		chk("present", present, 1'b0);
		entry(32'd80, 8'h01, 32'h0);
		entry(32'd120, 8'h02, 32'h7fff_0000);
		host.rd(pps_pkg::OFF_CNT, d, r);
		chk("count", d, 32'h2);
		wr(pps_pkg::OFF_DIG, 32'hff);
		chk("dig", dig, 8'h3c);
		c1 = 0;
		c2 = 0;
		wr(pps_pkg::OFF_CTRL, 32'h180);
		go(1'b1);
		chk("entry0", c1, 2);
		chk("entry1", c2, 3);
		chk("dig", dig, 8'hff);
		chk("completed", completed, 1'b1);
		chk("playing", playing, 1'b0);
		chk("present", present, 1'b1);
		$display("test start_on_load done");
		// Software start and counted repeats
		wr(pps_pkg::OFF_CFG, 32'h1);
		wr(pps_pkg::OFF_REPLO, 32'h3);
		c1 = 0;
		cmd(pps_pkg::C_START);
		go(1'b1);
		chk("repeats", c1, 6);
		wr(pps_pkg::OFF_REPLO, 32'h1);
		$display("test software done");
		// Each hardware edge code
		for (int s = 2; s <= 4; s++) begin
			wr(pps_pkg::OFF_CFG, s);
			trig_to(1'b1, s != 3);
			trig_to(1'b0, s != 2);
		end
		// One-shot needs a rearm for each start
		wr(pps_pkg::OFF_CFG, 32'ha);
		cmd(pps_pkg::C_REARM);
		trig_to(1'b1, 1'b1);
		trig_to(1'b0, 1'b0);
		trig_to(1'b1, 1'b0);
		cmd(pps_pkg::C_REARM);
		trig_to(1'b0, 1'b0);
		trig_to(1'b1, 1'b1);
		$display("test trigger done");
		// Endless repeat cut short by force-final
		wr(pps_pkg::OFF_CFG, 32'h1);
		wr(pps_pkg::OFF_REPLO, pps_pkg::ENDLESS[31:0]);
		wr(pps_pkg::OFF_REPHI, pps_pkg::ENDLESS[63:32]);
		cmd(pps_pkg::C_START);
		repeat (12) @(negedge clk_i);
		chk("started", playing, 1'b1);
		repeat (40) @(negedge clk_i);
		chk("endless", playing, 1'b1);
		cmd(pps_pkg::C_FORCE);
		chk("dig", dig, 8'hff);
		chk("playing", playing, 1'b0);
		// Constant refuses retrigger
		cmd(pps_pkg::C_CZERO);
		cmd(pps_pkg::C_START);
		go(1'b0);
		chk("present", present, 1'b1);
		// Force with no end state falls back to the constant
		cmd(pps_pkg::C_NEW);
		entry(32'd80, 8'h01, 32'h0);
		wr(pps_pkg::OFF_CTRL, 32'h100);
		cmd(pps_pkg::C_START);
		repeat (4) @(negedge clk_i);
		chk("dig", dig, 8'h01);
		cmd(pps_pkg::C_FORCE);
		chk("dig", dig, 8'h00);
		$display("test abort done");
		// Clock code and reset command
		wr(pps_pkg::OFF_CFG, 32'h20);
		chk("clk_sel", clk_sel, 2'h2);
		wr(pps_pkg::OFF_CFG, 32'h10);
		chk("clk_sel", clk_sel, 2'h1);
		cmd(pps_pkg::C_RST);
		chk("clk_sel", clk_sel, 2'h0);
		host.rd(pps_pkg::OFF_REPLO, d, r);
		chk("repeat", d, 32'h1);
		host.rd(pps_pkg::OFF_CFG, d, r);
		chk("cfg", d, 32'h0);
		$display("test clock done");
		end_of_test();
	end
endmodule
